//--- ftb_pkg.sv
// Shared constants, types and helpers for the flow-through burst static memory
package ftb_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Organisation variants
    localparam int FTB_WIDE_DW    = 36;
    localparam int FTB_WIDE_AW    = 19;
    localparam int FTB_WIDE_LANES = 4;
    localparam int FTB_NARW_DW    = 18;
    localparam int FTB_NARW_AW    = 20;
    localparam int FTB_NARW_LANES = 2;
    localparam int FTB_ADDR_MAX   = 20;
    localparam int FTB_LANE_MAX   = 4;
    localparam int FTB_BURST_W    = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Operation held by the registered cycle
    typedef enum logic [1:0] {
        FTB_OP_IDLE  = 2'b00,
        FTB_OP_READ  = 2'b01,
        FTB_OP_WRITE = 2'b10
    } ftb_op_t;

    // Decoded command of the present cycle
    typedef struct packed {
        ftb_op_t                   op;
        logic                      load;
        logic [FTB_ADDR_MAX-1:0]   addr;
    } ftb_cmd_t;

    // Whole state of the top module
    typedef struct packed {
        ftb_op_t                   op;
        logic [FTB_ADDR_MAX-1:0]   base;
        logic [FTB_BURST_W-1:0]    count;
        logic                      wr_pend;
        logic [FTB_ADDR_MAX-1:0]   wr_addr;
        logic [FTB_LANE_MAX-1:0]   wr_lanes;
        logic                      rd_phase;
    } ftb_state_t;

    localparam ftb_state_t FTB_STATE_RST = '{op: FTB_OP_IDLE, default: '0};
    localparam logic [FTB_BURST_W-1:0] FTB_COUNT_STEP = 2'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // Low address bits of a burst beat
    function automatic logic [FTB_BURST_W-1:0] ftb_burst_low(
        input logic [FTB_BURST_W-1:0] base,
        input logic [FTB_BURST_W-1:0] count,
        input logic                   linear
    );
        ftb_burst_low = linear ? FTB_BURST_W'(base + count) : (base ^ count);
    endfunction

endpackage

//--- ftb_burst.sv
// Burst address generator: linear or interleaved beat order
`timescale 1ns/10ps
module ftb_burst #(
    parameter int AW = ftb_pkg::FTB_WIDE_AW
) (
    // Burst state
    input  wire logic [AW-1:0]                   base,
    input  wire logic [ftb_pkg::FTB_BURST_W-1:0] count,
    // Order select
    input  wire logic                            linear_burst,
    // Beat address
    output logic      [AW-1:0]                   addr
);

    // Only the low bits wrap; upper bits stay on the loaded address
    always_comb begin
        addr = base;
        addr[ftb_pkg::FTB_BURST_W-1:0] =
            ftb_pkg::ftb_burst_low(base[ftb_pkg::FTB_BURST_W-1:0], count, linear_burst);
    end

endmodule

//--- ftb_mem.sv
// Storage array with byte-lane writes and a registered read port
`timescale 1ns/10ps
module ftb_mem #(
    parameter int DW    = ftb_pkg::FTB_WIDE_DW,
    parameter int AW    = ftb_pkg::FTB_WIDE_AW,
    parameter int LANES = ftb_pkg::FTB_WIDE_LANES
) (
    // Clock, reset, qualify
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             en,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [LANES-1:0] wr_lanes,
    input  wire logic [DW-1:0]    wr_data,
    // Read port
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [DW-1:0]    rd_data
);

    localparam int LW = DW / LANES;

    logic [DW-1:0] mem [2**AW];                 // [RL3]
    logic [DW-1:0] merged;

    // Read of the word being written sees the new lanes
    always_comb begin
        merged = mem[rd_addr];
        for (int l = 0; l < LANES; l++) begin
            if (wr_lanes[l]) begin
                merged[l*LW +: LW] = wr_data[l*LW +: LW];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (en && wr_en) begin
            for (int l = 0; l < LANES; l++) begin
                if (wr_lanes[l]) begin
                    mem[wr_addr][l*LW +: LW] <= wr_data[l*LW +: LW];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= '0;
        end else if (en && rd_en) begin
            rd_data <= (wr_en && wr_addr == rd_addr) ? merged : mem[rd_addr];
        end
    end

endmodule

//--- ftb_sram_top.sv
// Flow-through burst static memory with turnaround-free read/write sequencing
`timescale 1ns/10ps

// What this block does
// RL1 - Address, selects, write strobe, lane selects and data are captured on the rising clock.
// RL2 - With the clock qualify deasserted every edge is ignored and all state holds.
// RL3 - The array is 512K words of 36 bits or 1M words of 18 bits per build parameters.
// RL4 - A write updates only the byte lanes selected alongside the low write strobe.
// RL5 - Writes finish internally from the registered command and data alone.
// RL6 - Data drivers are off during the data phase of every write.
// RL7 - The output gate turns the drivers on or off combinationally, without the clock.
// RL8 - Three chip selects are sampled with the other inputs for banking and depth.
// RL9 - Reads and writes follow back to back in any mix with no dead cycles.
// RL10 - Read data appears in the cycle after the edge that captured the address.
// RL11 - Bursts step through addresses in linear or interleaved order as configured.
// RL12 - Sleep or deselection puts the device in its low-power state.
// RL13 - A cycle is selected only with selects low, high, low; otherwise no access and no drive. Here an advance cycle ignores the selects.
module ftb_sram_top #(
    parameter int DW    = ftb_pkg::FTB_WIDE_DW,
    parameter int AW    = ftb_pkg::FTB_WIDE_AW,
    parameter int LANES = ftb_pkg::FTB_WIDE_LANES
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Command
    input  wire logic [AW-1:0]    addr,
    input  wire logic             adv_load,
    input  wire logic             write_strobe_low,
    input  wire logic [LANES-1:0] lane_write_selects,
    input  wire logic             clock_qualify_low,
    // Chip selects
    input  wire logic             select_one_low,
    input  wire logic             select_two_high,
    input  wire logic             select_three_low,
    // Output control and configuration
    input  wire logic             drive_gate_low,
    input  wire logic             sleep_pin,
    input  wire logic             linear_burst,
    // Data bus
    input  wire logic [DW-1:0]    dq_in,
    output logic      [DW-1:0]    dq_out,
    output logic      [DW-1:0]    dq_oe,
    // Status
    output logic                  low_power
);

    ftb_pkg::ftb_state_t st_reg;
    ftb_pkg::ftb_state_t st_next;
    ftb_pkg::ftb_cmd_t   cmd;
    logic                en;
    logic                sel;
    logic [AW-1:0]       beat_addr;
    logic [ftb_pkg::FTB_BURST_W-1:0] count_inc;

    ////////////////////////////////////////////////////////////////////////////////
    // Cycle qualification and decode

    // Deasserted qualify stretches the previous cycle
    assign en = !clock_qualify_low;                                         // [RL2]

    // Sleep is folded into select so a sleeping part never starts an access
    assign sel = !select_one_low && select_two_high && !select_three_low    // [RL8] [RL13]
                 && !sleep_pin;

    assign count_inc = st_reg.count + ftb_pkg::FTB_COUNT_STEP;

    ftb_burst #(
        .AW(AW)
    ) u_burst (
        .base        (st_reg.base[AW-1:0]),
        .count       (count_inc),
        .linear_burst(linear_burst),
        .addr        (beat_addr)
    );

    always_comb begin
        cmd      = '{op: ftb_pkg::FTB_OP_IDLE, load: 1'b0, default: '0};
        cmd.addr = '0;
        if (adv_load && !sleep_pin) begin
            // Advance keeps the kind of the burst already running
            unique case (st_reg.op)
                ftb_pkg::FTB_OP_READ,
                ftb_pkg::FTB_OP_WRITE: begin
                    cmd.op             = st_reg.op;                         // [RL11]
                    cmd.addr[AW-1:0]   = beat_addr;
                end
                ftb_pkg::FTB_OP_IDLE: begin
                    cmd.op = ftb_pkg::FTB_OP_IDLE;
                end
                default: begin
                    cmd.op = ftb_pkg::FTB_OP_IDLE;
                end
            endcase
        end else if (!adv_load && sel) begin
            cmd.load           = 1'b1;
            cmd.addr[AW-1:0]   = addr;                                      // [RL1]
            cmd.op             = write_strobe_low ? ftb_pkg::FTB_OP_READ
                                                  : ftb_pkg::FTB_OP_WRITE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State update

    always_comb begin
        st_next = st_reg;
        if (en) begin
            st_next.op = cmd.op;
            if (cmd.load) begin
                st_next.base  = cmd.addr;                                   // [RL1]
                st_next.count = '0;
            end else if (cmd.op != ftb_pkg::FTB_OP_IDLE) begin
                st_next.count = count_inc;                                  // [RL11]
            end
            // Write data follows one cycle later; hold where it goes
            st_next.wr_pend  = (cmd.op == ftb_pkg::FTB_OP_WRITE);           // [RL5] [RL9]
            st_next.wr_addr  = cmd.addr;
            st_next.wr_lanes = '0;
            st_next.wr_lanes[LANES-1:0] = lane_write_selects;               // [RL4]
            // Read phase alone enables drivers, so write phases stay quiet
            st_next.rd_phase = (cmd.op == ftb_pkg::FTB_OP_READ);            // [RL6] [RL10]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg <= ftb_pkg::FTB_STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Storage: read issued at the capture edge, so data flows out next cycle

    ftb_mem #(
        .DW   (DW),
        .AW   (AW),
        .LANES(LANES)
    ) u_mem (
        .clk     (clk),
        .rst_b   (rst_b),
        .en      (en),
        .wr_en   (st_reg.wr_pend),                                          // [RL5]
        .wr_addr (st_reg.wr_addr[AW-1:0]),
        .wr_lanes(st_reg.wr_lanes[LANES-1:0]),                              // [RL4]
        .wr_data (dq_in),                                                   // [RL1]
        .rd_en   (cmd.op == ftb_pkg::FTB_OP_READ),                          // [RL10] [RL9]
        .rd_addr (cmd.addr[AW-1:0]),
        .rd_data (dq_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Output drive and power state

    // Gate and sleep are combinational; no clock needed to release the bus
    assign dq_oe = {DW{st_reg.rd_phase && !drive_gate_low && !sleep_pin}};  // [RL7] [RL6] [RL13]

    assign low_power = sleep_pin || (st_reg.op == ftb_pkg::FTB_OP_IDLE);    // [RL12]

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [AW-1:0] load_addr_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            load_addr_q <= '0;
        end else if (en && cmd.load) begin
            load_addr_q <= addr;
        end
    end

    capture_addr_a: assert property (                                       // [RL1]
        en && cmd.load |=> st_reg.base[AW-1:0] == load_addr_q && st_reg.count == '0)
        else $error("loaded address not captured");

    suspend_hold_a: assert property (                                       // [RL2]
        clock_qualify_low |=> $stable(st_reg) && $stable(dq_out))
        else $error("state moved while clock qualify deasserted");

    lane_capture_a: assert property (                                       // [RL4]
        en && cmd.op == ftb_pkg::FTB_OP_WRITE
        |=> st_reg.wr_pend && st_reg.wr_lanes[LANES-1:0] == $past(lane_write_selects))
        else $error("write lanes not captured");

    write_quiet_a: assert property (                                        // [RL6]
        en && cmd.op == ftb_pkg::FTB_OP_WRITE |=> dq_oe == '0)
        else $error("drivers on during write data phase");

    gate_off_a: assert property (                                           // [RL7]
        drive_gate_low || sleep_pin |-> dq_oe == '0)
        else $error("drivers on with gate high");

    read_flow_a: assert property (                                          // [RL10]
        en && cmd.op == ftb_pkg::FTB_OP_READ && !drive_gate_low
        ##1 !drive_gate_low && !sleep_pin |-> dq_oe == {DW{1'b1}})
        else $error("read data not driven next cycle");

    turnaround_a: assert property (                                         // [RL9]
        en && cmd.op == ftb_pkg::FTB_OP_READ ##1 en && cmd.op == ftb_pkg::FTB_OP_WRITE
        ##1 en && cmd.op == ftb_pkg::FTB_OP_READ |=> st_reg.rd_phase && !st_reg.wr_pend)
        else $error("turnaround lost a cycle");

    burst_step_a: assert property (                                         // [RL11]
        en && adv_load && !sleep_pin && st_reg.op != ftb_pkg::FTB_OP_IDLE
        |=> st_reg.count == $past(count_inc))
        else $error("burst count did not step");

    deselect_a: assert property (                                           // [RL13]
        en && !adv_load && !sel |=> st_reg.op == ftb_pkg::FTB_OP_IDLE && dq_oe == '0
                                    && low_power)
        else $error("deselected cycle made an access");

    sleep_power_a: assert property (                                        // [RL12]
        sleep_pin |-> low_power)
        else $error("sleep without low power");

    read_cov: cover property (en && cmd.op == ftb_pkg::FTB_OP_READ ##1 dq_oe[0]);
    wr_rd_cov: cover property (en && cmd.op == ftb_pkg::FTB_OP_WRITE
                               ##1 en && cmd.op == ftb_pkg::FTB_OP_READ);
    burst_cov: cover property (en && cmd.load ##1 en && adv_load ##1 en && adv_load
                               ##1 en && adv_load);
    suspend_cov: cover property (en && cmd.op == ftb_pkg::FTB_OP_READ
                                 ##1 clock_qualify_low [*2]);

endmodule

//--- ftb_master.sv
// Bus master model driving the command and data side of the memory
`timescale 1ns/10ps
module ftb_master (
    // Clock
    input  wire logic        clk,
    // Command
    output logic      [18:0] addr,
    output logic             adv_load,
    output logic             write_strobe_low,
    output logic      [3:0]  lane_write_selects,
    output logic             clock_qualify_low,
    // Chip selects
    output logic             select_one_low,
    output logic             select_two_high,
    output logic             select_three_low,
    // Output control and configuration
    output logic             drive_gate_low,
    output logic             sleep_pin,
    output logic             linear_burst,
    // Write data
    output logic      [35:0] dq_in
);
    initial begin
        addr = 19'h0;
        lane_write_selects = 4'h0;
        dq_in = 36'h0;
        {adv_load, clock_qualify_low, select_one_low, select_three_low} = 4'h0;
        {drive_gate_low, sleep_pin} = 2'h0;
        {write_strobe_low, select_two_high, linear_burst} = 3'h7;
    end

    task automatic step(input logic ld, input logic wb, input logic [18:0] a,
                        input logic [3:0] ln, input logic wd, input logic [35:0] d);
        @(negedge clk);
        adv_load = ld;
        write_strobe_low = wb;
        addr = a;
        lane_write_selects = ln;
        // Released lines flip so a stale value never passes as driven data
        dq_in = wd ? d : ~dq_in;
    endtask
endmodule

//--- tb_flow_through_sync_burst_sram.sv
// Self-checking bench for the flow-through burst static memory
`timescale 1ns/10ps
module tb_flow_through_sync_burst_sram;
    logic        clk;
    logic        rst_b;
    logic [18:0] addr;
    logic        adv_load;
    logic        write_strobe_low;
    logic [3:0]  lane_write_selects;
    logic        clock_qualify_low;
    logic        select_one_low;
    logic        select_two_high;
    logic        select_three_low;
    logic        drive_gate_low;
    logic        sleep_pin;
    logic        linear_burst;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic [35:0] dq_oe;
    logic        low_power;
    logic [35:0] mem [4];
    logic [35:0] pd;
    logic [35:0] eq;
    logic        pv;
    logic        ck;
    logic        eo;
    int          fails;
    int          total_checks;
    int          k;

    ftb_master mst (.clk, .addr, .adv_load, .write_strobe_low, .lane_write_selects,
        .clock_qualify_low, .select_one_low, .select_two_high, .select_three_low,
        .drive_gate_low, .sleep_pin, .linear_burst, .dq_in);
    ftb_sram_top dut (.clk, .rst_b, .addr, .adv_load, .write_strobe_low,
        .lane_write_selects, .clock_qualify_low, .select_one_low, .select_two_high,
        .select_three_low, .drive_gate_low, .sleep_pin, .linear_burst, .dq_in,
        .dq_out, .dq_oe, .low_power);

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_q(input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t bus got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_b(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic note(input string s);
        $display("test done: %s", s);
    endtask

    // Result of a command is seen one cycle late, so checks ride the next call
    task automatic cmd(input logic ld, input logic wb, input logic [18:0] a,
                       input logic [3:0] ln, input logic [35:0] d);
        mst.step(ld, wb, a, ln, pv, pd);
        if (ck) begin
            chk_q(dq_oe, {36{eo}});
            if (eo) chk_q(dq_out, eq);
        end
        ck = 1'b0;
        pv = !ld && !wb;
        pd = d;
    endtask

    task automatic rd(input int i);
        cmd(1'b0, 1'b1, 19'h10 + 19'(i), 4'h0, 36'h0);
        ck = 1'b1;
        eo = 1'b1;
        eq = mem[i];
    endtask

    task automatic wr(input int i, input logic [3:0] ln, input logic [35:0] d);
        cmd(1'b0, 1'b0, 19'h10 + 19'(i), ln, d);
        for (int l = 0; l < 4; l++) begin
            if (ln[l]) mem[i][l*9 +: 9] = d[l*9 +: 9];
        end
        ck = 1'b1;
        eo = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial begin
        #100000;
        fails++;
        $display("MISMATCH t=%0t run timed out", $time);
        close_out();
    end

    initial begin
        {rst_b, pv, ck, eo} = 4'h0;
        pd = 36'h0;
        eq = 36'h0;
        repeat (10) @(negedge clk);
        chk_q(dq_oe, 36'h0);
        chk_b(low_power, 1'b1);
        rst_b = 1'b1;
        for (k = 0; k < 4; k++) wr(k, 4'hF, 36'h9_1234_5670 + 36'(k * 17));
        for (k = 0; k < 4; k++) rd(k);
        note("write then read");
        wr(0, 4'h5, 36'hF_FFFF_FFFF);
        rd(0);
        wr(1, 4'hA, 36'h0);
        rd(1);
        note("lane writes");
        rd(2);
        rd(3);
        // Gate is asynchronous, so it is moved between edges on purpose
        mst.drive_gate_low = 1'b1;
        #2;
        chk_q(dq_oe, 36'h0);
        mst.drive_gate_low = 1'b0;
        #2;
        chk_q(dq_oe, {36{1'b1}});
        rd(0);
        mst.clock_qualify_low = 1'b1;
        repeat (3) begin
            @(negedge clk);
            chk_q(dq_out, mem[3]);
        end
        mst.clock_qualify_low = 1'b0;
        note("gate and suspend");
        rd(1);
        mst.sleep_pin = 1'b1;
        #2;
        chk_q(dq_oe, 36'h0);
        chk_b(low_power, 1'b1);
        @(negedge clk);
        mst.sleep_pin = 1'b0;
        #1;
        chk_q(dq_oe, 36'h0);
        chk_b(low_power, 1'b1);
        note("sleep");
        for (k = 0; k < 3; k++) begin
            cmd(1'b0, 1'b0, 19'h11, 4'hF, 36'h0);
            {mst.select_one_low, mst.select_two_high, mst.select_three_low} =
                3'b010 ^ (3'b100 >> k);
            ck = 1'b1;
            eo = 1'b0;
            cmd(1'b1, 1'b1, 19'h0, 4'h0, 36'h0);
            chk_b(low_power, 1'b1);
            {mst.select_one_low, mst.select_two_high, mst.select_three_low} = 3'b010;
        end
        rd(1);
        note("deselect");
        for (k = 0; k < 2; k++) begin
            rd(1);
            mst.linear_burst = k[0];
            for (int b = 1; b < 4; b++) begin
                cmd(1'b1, 1'b1, 19'h0, 4'h0, 36'h0);
                ck = 1'b1;
                eq = mem[k[0] ? (1 + b) % 4 : 1 ^ b];
            end
        end
        cmd(1'b0, 1'b1, 19'h10, 4'h0, 36'h0);
        note("bursts");
        close_out();
    end
endmodule
